// ---- rtl/idt_pkg.sv ----
// Shared constants and types for the instruction decode and timing block
package idt_pkg;
   localparam int WORD_W          = 14;
   localparam int FADDR_W         = 7;
   localparam int BITPOS_W        = 3;
   localparam int LIT_W           = 11;
   localparam int PTR_COUNT       = 2;
   localparam int OSC_PER_CYCLE   = 4;
   localparam int CYC_CNT_W       = 2;
   localparam real CLK_PERIOD_NS  = 5.0;

   localparam logic [FADDR_W-1:0] FADDR_MAX   = 7'h7F;
   localparam logic [5:0]         INDIRECT_HI = 6'h00;
   localparam logic [WORD_W-1:0]  WORD_RESET  = 14'h0000;

   typedef enum logic [1:0] {
      IDT_FMT_BYTE    = 2'h0,
      IDT_FMT_BIT     = 2'h1,
      IDT_FMT_LITCTRL = 2'h2
   } idt_fmt_type;

   typedef enum logic [3:0] {
      IDT_ST_FETCH = 4'h1,
      IDT_ST_EXEC  = 4'h2,
      IDT_ST_EXTRA = 4'h4,
      IDT_ST_FLUSH = 4'h8
   } idt_state_type;

   typedef struct packed {
      idt_fmt_type          fmt;
      logic [FADDR_W-1:0]   faddr;
      logic [BITPOS_W-1:0]  bitpos;
      logic                 dest;
      logic [LIT_W-1:0]     lit;
      logic                 ptr_num;
      logic [1:0]           mode;
      logic                 file_ref;
      logic                 file_wr;
      logic                 acc_wr;
      logic                 indirect;
      logic                 skip;
      logic                 two_cycle;
   } idt_dec_type;
endpackage

// ---- rtl/idt_phase_div.sv ----
// Quarter-phase divider: four oscillator clocks per instruction cycle
`timescale 1ns/10ps
`default_nettype none
module idt_phase_div #(
   parameter int PHASES = idt_pkg::OSC_PER_CYCLE
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_i,
   output logic [PHASES-1:0]      phase_o
);
   typedef struct packed {
      logic [PHASES-1:0] phase;
   } idt_div_type;

   idt_div_type r;
   idt_div_type next_r;

   always_comb
   begin
      next_r       = r;
      // Rotating one-hot phase, last bit ends the cycle
      next_r.phase = {r.phase[PHASES-2:0], r.phase[PHASES-1]};
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         r.phase <= {{(PHASES-1){1'b0}}, 1'b1};
      end
      else
      begin
         r <= next_r;
      end
   end

   assign phase_o = r.phase;
endmodule // idt_phase_div
`default_nettype wire

// ---- rtl/idt_decoder.sv ----
// Instruction word decoder and instruction-cycle timing sequencer
`timescale 1ns/10ps
`default_nettype none
// How it works
// - One 14-bit word holds the opcode and all operands.
// - Every opcode falls into byte, bit, or literal/control format.
// - Instructions take one cycle unless another rule adds cycles.
// - Absolute call and call via accumulator take two cycles.
// - Return, return with literal, return from interrupt take two cycles.
// - Jumps, branches and taken skips take two cycles.
// - PC change or true test adds a second cycle run as no-op.
// - Indirect access with pointer into program memory adds one cycle.
// - One instruction cycle is four oscillator clocks.
// - File-register instructions read, modify, then write; bit tests only read.
// - Destination bit 0 writes accumulator, 1 writes file register.
// - File address field selects 0x00 to 0x7F in the bank.
// - Bit instructions select one bit of an 8-bit register.
// - Pointer number selects indirect pair 0 or 1.
// - Mode field selects pre/post increment or decrement.
// - Don't-care bits never change decoding.
module idt_decoder (
   input  wire logic                          ref_clk_i,
   input  wire logic                          rst_i,
   input  wire logic [idt_pkg::WORD_W-1:0]    prog_word_i,
   input  wire logic                          cond_true_i,
   input  wire logic                          pc_write_i,
   input  wire logic [idt_pkg::PTR_COUNT-1:0] ptr_in_prog_i,
   output logic                               fetch_o,
   output logic [1:0]                         fmt_o,
   output logic [idt_pkg::FADDR_W-1:0]        faddr_o,
   output logic [idt_pkg::BITPOS_W-1:0]       bitpos_o,
   output logic                               dest_o,
   output logic [idt_pkg::LIT_W-1:0]          lit_o,
   output logic                               ptr_num_o,
   output logic [1:0]                         mode_o,
   output logic                               file_rd_o,
   output logic                               file_wr_o,
   output logic                               acc_wr_o,
   output logic                               nop_o,
   output logic                               extra_o,
   output logic                               done_o,
   output logic [idt_pkg::CYC_CNT_W-1:0]      cycles_o
);
   typedef struct packed {
      idt_pkg::idt_state_type          st;
      idt_pkg::idt_dec_type            dec;
      logic                            flush_pend;
      logic                            fetch;
      logic                            file_rd;
      logic                            file_wr;
      logic                            acc_wr;
      logic                            done;
      logic [idt_pkg::CYC_CNT_W-1:0]   cyc;
      logic [idt_pkg::CYC_CNT_W-1:0]   cycles;
   } idt_core_type;

   idt_core_type r;
   idt_core_type next_r;
   logic [idt_pkg::OSC_PER_CYCLE-1:0] phase;

   idt_phase_div #(
      .PHASES (idt_pkg::OSC_PER_CYCLE)
   ) u_div (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .phase_o   (phase)
   );

   function automatic idt_pkg::idt_dec_type decode(
      input logic [idt_pkg::WORD_W-1:0] w
   );
      idt_pkg::idt_dec_type d;
      d          = '0;
      d.fmt      = idt_pkg::IDT_FMT_LITCTRL;
      d.faddr    = w[6:0] & idt_pkg::FADDR_MAX;
      d.bitpos   = w[9:7];
      d.dest     = w[7];
      d.lit      = w[10:0];
      casez (w)
         14'b00_0000_0000_1000,
         14'b00_0000_0000_1001:
            d.two_cycle = 1'b1;
         14'b00_0000_0000_1010:
            d.two_cycle = 1'b1;
         14'b00_0000_0000_1011:
            d.two_cycle = 1'b1;
         14'b00_0000_0001_????:
         begin
            d.indirect = 1'b1;
            d.ptr_num  = w[2];
            d.mode     = w[1:0];
            d.acc_wr   = ~w[3];
         end
         14'b00_0000_0???_????:
            d.fmt = idt_pkg::IDT_FMT_LITCTRL;
         14'b00_0001_0000_00??:
         begin
            d.fmt    = idt_pkg::IDT_FMT_BYTE;
            d.acc_wr = 1'b1;
         end
         14'b00_????_????_????:
         begin
            d.fmt      = idt_pkg::IDT_FMT_BYTE;
            d.file_ref = 1'b1;
            d.file_wr  = w[7];
            d.acc_wr   = ~w[7];
            d.skip     = (w[11:8] == 4'hB) || (w[11:8] == 4'hF);
         end
         14'b01_????_????_????:
         begin
            d.fmt      = idt_pkg::IDT_FMT_BIT;
            d.file_ref = 1'b1;
            d.file_wr  = ~w[11];
            d.skip     = w[11];
         end
         14'b10_????_????_????:
            d.two_cycle = 1'b1;
         14'b11_001?_????_????:
            d.two_cycle = 1'b1;
         14'b11_0100_????_????:
         begin
            d.two_cycle = 1'b1;
            d.acc_wr    = 1'b1;
         end
         14'b11_1111_????_????:
         begin
            d.indirect = 1'b1;
            d.ptr_num  = w[6];
            d.acc_wr   = ~w[7];
         end
         14'b11_0001_????_????:
            d.fmt = idt_pkg::IDT_FMT_LITCTRL;
         14'b11_0101_????_????, 14'b11_0110_????_????,
         14'b11_0111_????_????, 14'b11_1011_????_????,
         14'b11_1101_????_????:
         begin
            d.fmt      = idt_pkg::IDT_FMT_BYTE;
            d.file_ref = 1'b1;
            d.file_wr  = w[7];
            d.acc_wr   = ~w[7];
         end
         default:
            d.acc_wr = 1'b1;
      endcase
      // Indirect register addressed through the file field
      if (d.file_ref && (w[6:1] == idt_pkg::INDIRECT_HI))
      begin
         d.indirect = 1'b1;
         d.ptr_num  = w[0];
      end
      return d;
   endfunction

   always_comb
   begin
      next_r         = r;
      next_r.fetch   = 1'b0;
      next_r.file_rd = 1'b0;
      next_r.file_wr = 1'b0;
      next_r.acc_wr  = 1'b0;
      next_r.done    = 1'b0;
      case (r.st)
         idt_pkg::IDT_ST_FETCH:
         begin
            if (phase[idt_pkg::OSC_PER_CYCLE-1])
            begin
               next_r.dec   = decode(prog_word_i);
               next_r.fetch = 1'b1;
               next_r.cyc   = '0;
               next_r.st    = idt_pkg::IDT_ST_EXEC;
            end
         end
         idt_pkg::IDT_ST_EXEC:
         begin
            // Read always precedes the write, even for write-only ops
            next_r.file_rd = phase[1] & r.dec.file_ref;
            if (phase[idt_pkg::OSC_PER_CYCLE-1])
            begin
               next_r.file_wr = r.dec.file_wr;
               next_r.acc_wr  = r.dec.acc_wr;
               next_r.cyc     = r.cyc + 2'h1;
               next_r.flush_pend = r.dec.two_cycle | pc_write_i
                  | (r.dec.skip & cond_true_i);
               if (r.dec.indirect && ptr_in_prog_i[r.dec.ptr_num])
               begin
                  next_r.st = idt_pkg::IDT_ST_EXTRA;
               end
               else if (r.dec.two_cycle | pc_write_i
                        | (r.dec.skip & cond_true_i))
               begin
                  next_r.st = idt_pkg::IDT_ST_FLUSH;
               end
               else
               begin
                  next_r.done   = 1'b1;
                  next_r.cycles = r.cyc + 2'h1;
                  next_r.dec    = decode(prog_word_i);
                  next_r.fetch  = 1'b1;
                  next_r.cyc    = '0;
               end
            end
         end
         idt_pkg::IDT_ST_EXTRA:
         begin
            if (phase[idt_pkg::OSC_PER_CYCLE-1])
            begin
               next_r.cyc = r.cyc + 2'h1;
               if (r.flush_pend)
               begin
                  next_r.st = idt_pkg::IDT_ST_FLUSH;
               end
               else
               begin
                  next_r.done   = 1'b1;
                  next_r.cycles = r.cyc + 2'h1;
                  next_r.dec    = decode(prog_word_i);
                  next_r.fetch  = 1'b1;
                  next_r.cyc    = '0;
                  next_r.st     = idt_pkg::IDT_ST_EXEC;
               end
            end
         end
         idt_pkg::IDT_ST_FLUSH:
         begin
            // Last cycle executes as a no-op
            if (phase[idt_pkg::OSC_PER_CYCLE-1])
            begin
               next_r.flush_pend = 1'b0;
               next_r.done       = 1'b1;
               next_r.cycles     = r.cyc + 2'h1;
               next_r.dec        = decode(prog_word_i);
               next_r.fetch      = 1'b1;
               next_r.cyc        = '0;
               next_r.st         = idt_pkg::IDT_ST_EXEC;
            end
         end
         default:
            next_r.st = idt_pkg::IDT_ST_FETCH;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         r    <= '0;
         r.st <= idt_pkg::IDT_ST_FETCH;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign fetch_o   = r.fetch;
   assign fmt_o     = r.dec.fmt;
   assign faddr_o   = r.dec.faddr;
   assign bitpos_o  = r.dec.bitpos;
   assign dest_o    = r.dec.dest;
   assign lit_o     = r.dec.lit;
   assign ptr_num_o = r.dec.ptr_num;
   assign mode_o    = r.dec.mode;
   assign file_rd_o = r.file_rd;
   assign file_wr_o = r.file_wr;
   assign acc_wr_o  = r.acc_wr;
   // One-hot state bits drive the flags straight from their flops
   assign nop_o     = r.st[3];
   assign extra_o   = r.st[2];
   assign done_o    = r.done;
   assign cycles_o  = r.cycles;
endmodule // idt_decoder
`default_nettype wire

// ---- testbench/idt_decoder_assertions.sv ----
// Port-level timing checks for the instruction decoder
`timescale 1ns/10ps
`default_nettype none
module idt_decoder_assertions (
   input wire logic                          ref_clk_i,
   input wire logic                          rst_i,
   input wire logic                          fetch_o,
   input wire logic [idt_pkg::FADDR_W-1:0]   faddr_o,
   input wire logic                          file_rd_o,
   input wire logic                          file_wr_o,
   input wire logic                          acc_wr_o,
   input wire logic                          nop_o,
   input wire logic                          extra_o,
   input wire logic                          done_o,
   input wire logic [idt_pkg::CYC_CNT_W-1:0] cycles_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   property p_fetch_gap; fetch_o |=> !fetch_o [*3]; endproperty
   property p_done_fetch; done_o |-> fetch_o; endproperty
   property p_cyc_range; done_o |-> cycles_o != 2'h0; endproperty
   property p_one_cycle; done_o && cycles_o == 2'h1 |-> $past(fetch_o, 4);
   endproperty
   property p_nop_len; $rose(nop_o) |-> nop_o [*4] ##1 !nop_o; endproperty
   property p_extra_len; $rose(extra_o) |-> extra_o [*4] ##1 !extra_o;
   endproperty
   property p_rd_time; file_rd_o |-> $past(fetch_o, 2); endproperty
   property p_dest_excl; file_wr_o |-> !acc_wr_o; endproperty
   property p_wr_done; file_wr_o |-> ##[0:8] done_o; endproperty
   property p_fields; !fetch_o |-> $stable(faddr_o); endproperty
   a_fetch_gap: assert property (p_fetch_gap)
      else $error("fetch closer than four clocks");
   a_done_fetch: assert property (p_done_fetch)
      else $error("done without next fetch");
   a_cyc_range: assert property (p_cyc_range)
      else $error("zero cycle count");
   a_one_cycle: assert property (p_one_cycle)
      else $error("single cycle not four clocks");
   a_nop_len: assert property (p_nop_len)
      else $error("no-op cycle length wrong");
   a_extra_len: assert property (p_extra_len)
      else $error("extra cycle length wrong");
   a_rd_time: assert property (p_rd_time)
      else $error("file read misplaced");
   a_dest_excl: assert property (p_dest_excl)
      else $error("both destinations written");
   a_wr_done: assert property (p_wr_done)
      else $error("write without completion");
   a_fields: assert property (p_fields)
      else $error("operand moved mid-instruction");
   c_nop: cover property (nop_o);
   c_extra: cover property (extra_o);
   c_three: cover property (done_o && cycles_o == 2'h3);
endmodule // idt_decoder_assertions
`default_nettype wire

// ---- testbench/idt_prog_mem.sv ----
// Program memory model presenting instruction words
`timescale 1ns/10ps
`default_nettype none
module idt_prog_mem (
   input  wire logic                       ref_clk_i,
   input  wire logic                       adv_i,
   output logic [idt_pkg::WORD_W-1:0]      word_o = idt_pkg::WORD_RESET
);
   logic [idt_pkg::WORD_W-1:0] q[$];
   // Empty memory shows a toggling pattern, never a held word
   always @(negedge ref_clk_i)
   begin
      if (adv_i && q.size() > 0)
         void'(q.pop_front());
      word_o <= (q.size() > 0) ? q[0] : ~word_o;
   end
endmodule // idt_prog_mem
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the instruction decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin failures++; \
   $display("unexpected %s exp %0h got %0h", n, e, s); end end
module testbench;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cond_true_i = 1'b0;
   logic pc_write_i = 1'b0;
   logic [1:0] ptr_in_prog_i = 2'h0;
   logic [13:0] prog_word_i;
   logic fetch_o, dest_o, ptr_num_o, file_rd_o, file_wr_o, acc_wr_o;
   logic nop_o, extra_o, done_o;
   logic [1:0] fmt_o, mode_o, cycles_o;
   logic [6:0] faddr_o;
   logic [2:0] bitpos_o;
   logic [10:0] lit_o;
   int failures = 0;
   int checked = 0;
   int seed = 32'hdad9;
   int cyc = 0;
   logic [13:0] base [16] = '{14'h0700, 14'h0B00, 14'h0F00, 14'h1000,
      14'h1800, 14'h1C00, 14'h3E00, 14'h2000, 14'h2800, 14'h3200,
      14'h000A, 14'h000B, 14'h0009, 14'h0100, 14'h0080, 14'h0010};
   logic [13:0] mask [16] = '{14'h00FF, 14'h00FF, 14'h00FF, 14'h03FF,
      14'h03FF, 14'h03FF, 14'h00FF, 14'h07FF, 14'h07FF, 14'h01FF,
      14'h0000, 14'h0000, 14'h0000, 14'h0003, 14'h007F, 14'h000F};

   idt_decoder i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .prog_word_i(prog_word_i), .cond_true_i(cond_true_i),
      .pc_write_i(pc_write_i), .ptr_in_prog_i(ptr_in_prog_i),
      .fetch_o(fetch_o), .fmt_o(fmt_o), .faddr_o(faddr_o),
      .bitpos_o(bitpos_o), .dest_o(dest_o), .lit_o(lit_o),
      .ptr_num_o(ptr_num_o), .mode_o(mode_o), .file_rd_o(file_rd_o),
      .file_wr_o(file_wr_o), .acc_wr_o(acc_wr_o), .nop_o(nop_o),
      .extra_o(extra_o), .done_o(done_o), .cycles_o(cycles_o));
   idt_prog_mem i_mem (.ref_clk_i(ref_clk_i), .adv_i(fetch_o),
      .word_o(prog_word_i));

   task automatic finish_test();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      forever #(idt_pkg::CLK_PERIOD_NS / 2.0) ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         finish_test();
      end
   end

   initial
   begin
      logic [13:0] w;
      logic [13:0] exp_q[$];
      logic rd, fwr, awr;
      bit fr, sk, jmp, ind, two, mv;
      logic pn;
      logic [1:0] md;
      int t, r, n, fm, cy;
      for (int b = 0; b < 4; b++)
      begin
         rst_i = 1'b1;
         // Let reset clear the fetch pulse before the memory is refilled
         @(negedge ref_clk_i);
         ptr_in_prog_i = 2'(b);
         i_mem.q.delete();
         exp_q.delete();
         for (int i = 0; i < 26; i++)
         begin
            t = $unsigned($random(seed)) % 16;
            r = $random(seed);
            w = base[t] | (14'(r) & mask[t]);
            if (r[20])
               w[6:1] = 6'h00;
            i_mem.q.push_back(w);
            exp_q.push_back(w);
         end
         repeat (7) @(negedge ref_clk_i);
         rst_i = 1'b0;
         for (int i = 0; i < 24; i++)
         begin
            n = 0;
            while (fetch_o !== 1'b1 && n < 40)
            begin
               @(negedge ref_clk_i);
               n++;
            end
            `CHK("fetch", 1'b1, fetch_o)
            w = exp_q.pop_front();
            fm = (w[13:12] == 2'h1) ? 1 :
               (w[13:12] == 2'h0 && (w[11:8] != 4'h0 || w[7])) ? 0 : 2;
            fr = (fm == 1) || (fm == 0 && w[13:2] != 12'h040);
            sk = w[13:8] inside {6'h0B, 6'h0F} || w[13:11] == 3'h3;
            jmp = w[13:12] == 2'h2 || w[13:9] == 5'h19 ||
               w inside {14'h0009, 14'h000A, 14'h000B};
            ind = fr && w[6:1] == 6'h00 && ptr_in_prog_i[w[0]];
            mv = w[13:4] == 10'h001;
            ind = ind || (mv && ptr_in_prog_i[w[2]]);
            pn = (fr && w[6:1] == 6'h00) ? w[0] : (mv ? w[2] : 1'b0);
            md = mv ? w[1:0] : 2'h0;
            cond_true_i = 1'($random(seed));
            pc_write_i = ($random(seed) & 7) == 0;
            two = jmp || (sk && cond_true_i) || pc_write_i;
            cy = 1 + int'(ind) + int'(two);
            `CHK("fmt", 2'(fm), fmt_o)
            if (fm < 2) `CHK("faddr", w[6:0], faddr_o)
            if (fm == 1) `CHK("bitpos", w[9:7], bitpos_o)
            if (fm == 0 && fr) `CHK("dest", w[7], dest_o)
            if (w[13:12] == 2'h2) `CHK("lit", w[10:0], lit_o)
            `CHK("ptr_num", pn, ptr_num_o)
            `CHK("mode", md, mode_o)
            {rd, fwr, awr} = 3'h0;
            n = 0;
            do
            begin
               @(negedge ref_clk_i);
               rd = rd | file_rd_o;
               fwr = fwr | file_wr_o;
               awr = awr | acc_wr_o;
               n++;
            end while (done_o !== 1'b1 && n < 20);
            `CHK("done", 1'b1, done_o)
            `CHK("cycles", 2'(cy), cycles_o)
            `CHK("file_rd", fr, rd)
            if (w[13:8] inside {6'h07, 6'h0B, 6'h0F})
            begin
               `CHK("file_wr", w[7], fwr)
               `CHK("acc_wr", !w[7], awr)
            end
         end
         $display("test batch %0d done", b);
      end
      finish_test();
   end
endmodule // testbench

bind idt_decoder idt_decoder_assertions u_chk (.ref_clk_i(ref_clk_i),
   .rst_i(rst_i), .fetch_o(fetch_o), .faddr_o(faddr_o),
   .file_rd_o(file_rd_o), .file_wr_o(file_wr_o), .acc_wr_o(acc_wr_o),
   .nop_o(nop_o), .extra_o(extra_o), .done_o(done_o),
   .cycles_o(cycles_o));
`default_nettype wire
